// [logic/frs_pkg.sv]
// Constants, types and timing counts for the flash reset sequencer.
// Assumes one 200 MHz clock shared by both ends of the link.
package frs_pkg;

   // Clock
   localparam int CLK_PERIOD_NS = 5;

   // Interval figures in their own units
   localparam int RESET_SETUP_NS = 50;
   localparam int RESET_HOLD_NS = 150;
   localparam int RESET_PULSE_NS = 200;
   localparam int PULSE_HOLD_US = 100;
   localparam int SELECT_HIGH_NS = 50;
   localparam int POWER_UP_US = 300;
   localparam int SOFT_RESET_US = 10;

   // Minimum times, rounded up to whole cycles
   localparam int RS_CYC = (RESET_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RH_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RP_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CS_CYC = (SELECT_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RPH_CYC_DEF = (PULSE_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PU_CYC_DEF = (POWER_UP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SW_CYC_DEF = (SOFT_RESET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Interval counter, wide enough for the power-up count
   typedef logic [16:0] frs_cnt_t;

   // Configuration bit positions
   localparam int QUAD_EN_BIT = 1;
   localparam int QPI_EN_BIT = 3;
   localparam int SHARED_RST_BIT = 7;

   // Command codes
   localparam logic [7:0] RESET_ENABLE_CMD = 8'h66;
   localparam logic [7:0] RESET_CMD = 8'h99;

   // Device sequencer states
   typedef enum logic [1:0] {
      FRS_POR = 2'b00,
      FRS_READY = 2'b01,
      FRS_HW = 2'b11,
      FRS_SW = 2'b10
   } frs_dev_state_e;

   // Host sequencer states
   typedef enum logic [2:0] {
      FRS_H_PU = 3'b000,
      FRS_H_SETUP = 3'b001,
      FRS_H_IDLE = 3'b011,
      FRS_H_CMD = 3'b010,
      FRS_H_GAP = 3'b110,
      FRS_H_RST_LOW = 3'b111,
      FRS_H_RST_HOLD = 3'b101,
      FRS_H_SW_WAIT = 3'b100
   } frs_host_state_e;

endpackage

// [logic/frs_link_if.sv]
// Link between host controller and flash reset logic.
// Both ends run on the same clock; the shared pin has a pull-up.
interface frs_link_if;
   logic cs_n;
   logic rst_n;
   logic cmd_valid;
   logic [7:0] cmd_byte;
   logic host_io3_out;
   logic host_io3_oe;
   logic dev_io3_out;
   logic dev_io3_oe;
   logic io3_level;

   // Device drive takes precedence; undriven pin floats high
   assign io3_level = dev_io3_oe ? dev_io3_out : (host_io3_oe ? host_io3_out : 1'b1);

   modport dev (
      input cs_n,
      input rst_n,
      input cmd_valid,
      input cmd_byte,
      input io3_level,
      output dev_io3_out,
      output dev_io3_oe
   );

   modport host (
      output cs_n,
      output rst_n,
      output cmd_valid,
      output cmd_byte,
      output host_io3_out,
      output host_io3_oe,
      input io3_level
   );
endinterface

// [logic/frs_device.sv]
// Flash-side reset sequencer: power-on, pin and software resets.
// Assumes the host end shares REF_CLK, so link inputs need no synchroniser.

// Overview of operation
// R1: Host reissues operations cut by hardware reset.
// R2: Hardware reset ignored during software reset.
// R3: Host stays deselected during power-up interval.
// R4: Reset pins ignored while power-on reset runs.
// R5: Host holds select high reset-hold after pin.
// R6: Reset pin high past setup before new pulse.
// R7: Shared pin resets after select-high or non-quad.
// R8: Long low pulse restores registers within hold.
// R9: Shared pin ignored select-high; data under select.
// R10: Failed power-on makes pin reset full power-on.
// R11: Enable then reset command performs software reset.
// R12: Nonvolatile enable clear makes pin data only.
// R13: Shared reset tri-states, ignores commands, returns standby.
// R14: Host never drives shared pin low early.
// R15: Device drives shared pin high after quad read.
// R16: Host drives shared pin high after quad write.
// R17: Non-quad host raises select during pulse hold.
// R18: Pulse width plus hold covers pulse-hold time.
// R19: All intervals are rounded-up clock counters.
module frs_device #(
   parameter int PU_CYC = frs_pkg::PU_CYC_DEF,
   parameter int RPH_CYC = frs_pkg::RPH_CYC_DEF,
   parameter int SW_CYC = frs_pkg::SW_CYC_DEF
) (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   // Link to host
   frs_link_if.dev LINK,
   // Configuration registers
   input wire logic [7:0] CONFIG_ONE,
   input wire logic [7:0] CONFIG_TWO,
   input wire logic [7:0] CONFIG_TWO_NV,
   // Core status and data lane
   input wire logic POR_FAULT,
   input wire logic QUAD_READ,
   input wire logic IO3_TX,
   input wire logic IO3_TX_EN,
   // Sequencer status
   output logic POR_BUSY,
   output logic HW_RESET_BUSY,
   output logic SW_RESET_BUSY,
   output logic REG_RESTORE,
   output logic CMD_READY,
   // Accepted commands and received data
   output logic CMD_VALID_OUT,
   output logic [7:0] CMD_BYTE_OUT,
   output logic IO3_RX
);

   frs_pkg::frs_dev_state_e state_reg, state_next;
   frs_pkg::frs_cnt_t timer_reg, timer_next;
   frs_pkg::frs_cnt_t cs_high_cnt_reg, cs_high_cnt_next;
   frs_pkg::frs_cnt_t rst_low_cnt_reg, rst_low_cnt_next;
   frs_pkg::frs_cnt_t io3_low_cnt_reg, io3_low_cnt_next;
   logic por_ok_reg, por_ok_next;
   logic arm_reg, arm_next;
   logic quad_rd_seen_reg, quad_rd_seen_next;
   logic cs_prev_reg;
   logic dev_io3_oe_reg, dev_io3_out_reg;
   logic por_busy_reg, hw_busy_reg, sw_busy_reg, restore_reg, cmd_ready_reg;
   logic cmd_valid_out_reg, io3_rx_reg;
   logic [7:0] cmd_byte_out_reg;

   // Decoding
   wire in_por = (state_reg == frs_pkg::FRS_POR);
   wire in_ready = (state_reg == frs_pkg::FRS_READY);
   wire in_hw = (state_reg == frs_pkg::FRS_HW);
   wire in_sw = (state_reg == frs_pkg::FRS_SW);
   wire quad_active = CONFIG_ONE[frs_pkg::QUAD_EN_BIT] & CONFIG_TWO[frs_pkg::QPI_EN_BIT];
   wire shared_en = CONFIG_TWO_NV[frs_pkg::SHARED_RST_BIT];
   wire cs_high_ok = LINK.cs_n & (cs_high_cnt_reg == frs_pkg::frs_cnt_t'(frs_pkg::CS_CYC));
   // Quad mode needs the select-high window before the pin counts as reset
   wire io3_window = shared_en & (~quad_active | cs_high_ok); // see R7 see R9 see R12
   wire io3_low = io3_window & ~LINK.io3_level;
   wire rst_low = ~LINK.rst_n;
   // Only the ready state watches the pins: power-on and soft reset mask them
   wire watch_pins = in_ready; // see R4 see R2
   wire rst_trig = watch_pins & rst_low & (rst_low_cnt_reg == frs_pkg::frs_cnt_t'(frs_pkg::RP_CYC)); // see R8
   wire io3_trig = watch_pins & io3_low & (io3_low_cnt_reg == frs_pkg::frs_cnt_t'(frs_pkg::RP_CYC)); // see R8
   wire hw_trig = rst_trig | io3_trig;
   wire cmd_take = in_ready & LINK.cmd_valid & ~LINK.cs_n; // see R13
   wire is_enable = (LINK.cmd_byte == frs_pkg::RESET_ENABLE_CMD);
   wire is_reset = (LINK.cmd_byte == frs_pkg::RESET_CMD);
   wire sw_trig = cmd_take & arm_reg & is_reset & LINK.rst_n & ~hw_trig; // see R11
   wire cs_fall = cs_prev_reg & ~LINK.cs_n;
   // Holding the pin high right after a quad read keeps the pull-up from being beaten
   wire drive_high = in_ready & LINK.cs_n & quad_rd_seen_reg & ~cs_high_ok; // see R15
   wire drive_data = in_ready & ~LINK.cs_n & IO3_TX_EN; // see R9
   wire io3_oe_next = drive_high | drive_data; // see R13
   wire io3_out_next = drive_high | IO3_TX;

   wire frs_pkg::frs_cnt_t timer_limit = in_por ? frs_pkg::frs_cnt_t'(PU_CYC - 1) :
                                         in_hw ? frs_pkg::frs_cnt_t'(RPH_CYC - 1) :
                                         frs_pkg::frs_cnt_t'(SW_CYC - 1); // see R19
   wire timer_done = (timer_reg == timer_limit);

   always_comb
   begin
      state_next = state_reg;
      por_ok_next = por_ok_reg;
      unique case (state_reg)
         frs_pkg::FRS_POR:
         begin
            if (timer_done)
            begin
               state_next = frs_pkg::FRS_READY; // see R3
               por_ok_next = ~POR_FAULT;
            end
         end
         frs_pkg::FRS_READY:
         begin
            if (hw_trig)
               state_next = por_ok_reg ? frs_pkg::FRS_HW : frs_pkg::FRS_POR; // see R10
            else if (sw_trig)
               state_next = frs_pkg::FRS_SW;
         end
         frs_pkg::FRS_HW:
         begin
            if (timer_done)
               state_next = frs_pkg::FRS_READY; // see R13
         end
         frs_pkg::FRS_SW:
         begin
            if (timer_done)
               state_next = frs_pkg::FRS_READY; // see R2
         end
      endcase
   end

   always_comb
   begin
      timer_next = (state_next != state_reg) ? '0 : timer_reg + 1'b1;
      cs_high_cnt_next = cs_high_cnt_reg;
      if (!LINK.cs_n)
         cs_high_cnt_next = '0;
      else if (!cs_high_ok)
         cs_high_cnt_next = cs_high_cnt_reg + 1'b1;
      rst_low_cnt_next = '0;
      if (watch_pins && rst_low && !rst_trig)
         rst_low_cnt_next = rst_low_cnt_reg + 1'b1;
      io3_low_cnt_next = '0;
      if (watch_pins && io3_low && !io3_trig)
         io3_low_cnt_next = io3_low_cnt_reg + 1'b1;
      arm_next = arm_reg;
      if (!in_ready)
         arm_next = 1'b0;
      else if (cmd_take)
         arm_next = is_enable; // see R11
      quad_rd_seen_next = quad_rd_seen_reg;
      if (!in_ready || cs_fall)
         quad_rd_seen_next = 1'b0;
      else if (!LINK.cs_n && QUAD_READ && quad_active)
         quad_rd_seen_next = 1'b1;
   end

   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         state_reg <= frs_pkg::FRS_POR;
         timer_reg <= '0;
         cs_high_cnt_reg <= '0;
         rst_low_cnt_reg <= '0;
         io3_low_cnt_reg <= '0;
         por_ok_reg <= 1'b0;
         arm_reg <= 1'b0;
         quad_rd_seen_reg <= 1'b0;
         cs_prev_reg <= 1'b1;
      end
      else
      begin
         state_reg <= state_next;
         timer_reg <= timer_next;
         cs_high_cnt_reg <= cs_high_cnt_next;
         rst_low_cnt_reg <= rst_low_cnt_next;
         io3_low_cnt_reg <= io3_low_cnt_next;
         por_ok_reg <= por_ok_next;
         arm_reg <= arm_next;
         quad_rd_seen_reg <= quad_rd_seen_next;
         cs_prev_reg <= LINK.cs_n;
      end
   end

   // Registered outputs
   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         dev_io3_oe_reg <= 1'b0;
         dev_io3_out_reg <= 1'b1;
         por_busy_reg <= 1'b1;
         hw_busy_reg <= 1'b0;
         sw_busy_reg <= 1'b0;
         restore_reg <= 1'b0;
         cmd_ready_reg <= 1'b0;
         cmd_valid_out_reg <= 1'b0;
         cmd_byte_out_reg <= 8'h00;
         io3_rx_reg <= 1'b1;
      end
      else
      begin
         dev_io3_oe_reg <= io3_oe_next & (state_next == frs_pkg::FRS_READY);
         dev_io3_out_reg <= io3_out_next;
         por_busy_reg <= (state_next == frs_pkg::FRS_POR);
         hw_busy_reg <= (state_next == frs_pkg::FRS_HW);
         sw_busy_reg <= (state_next == frs_pkg::FRS_SW);
         restore_reg <= hw_trig | sw_trig; // see R8
         cmd_ready_reg <= (state_next == frs_pkg::FRS_READY);
         cmd_valid_out_reg <= cmd_take & ~hw_trig;
         if (cmd_take)
            cmd_byte_out_reg <= LINK.cmd_byte;
         if (!LINK.cs_n)
            io3_rx_reg <= LINK.io3_level;
      end
   end

   assign LINK.dev_io3_oe = dev_io3_oe_reg;
   assign LINK.dev_io3_out = dev_io3_out_reg;
   assign POR_BUSY = por_busy_reg;
   assign HW_RESET_BUSY = hw_busy_reg;
   assign SW_RESET_BUSY = sw_busy_reg;
   assign REG_RESTORE = restore_reg;
   assign CMD_READY = cmd_ready_reg;
   assign CMD_VALID_OUT = cmd_valid_out_reg;
   assign CMD_BYTE_OUT = cmd_byte_out_reg;
   assign IO3_RX = io3_rx_reg;

endmodule

// [logic/frs_host.sv]
// Host-side reset sequencer: select, reset pins and reset commands.
// Assumes the device end shares REF_CLK.
module frs_host #(
   parameter int PU_CYC = frs_pkg::PU_CYC_DEF,
   parameter int RPH_CYC = frs_pkg::RPH_CYC_DEF,
   parameter int SW_CYC = frs_pkg::SW_CYC_DEF
) (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   // Link to device
   frs_link_if.host LINK,
   // Requests
   input wire logic HW_RESET_REQ,
   input wire logic USE_SHARED_PIN,
   input wire logic SW_RESET_REQ,
   input wire logic CMD_REQ,
   input wire logic [7:0] CMD_CODE,
   input wire logic QUAD_WRITE,
   // Interrupted operation tracking
   input wire logic OP_IN_FLIGHT,
   input wire logic REISSUE_ACK,
   // Status
   output logic HOST_READY,
   output logic CMD_SENT,
   output logic REISSUE_NEEDED
);

   // Pulse plus hold must cover the device's pulse-hold time
   localparam int HOLD_CYC = (frs_pkg::RH_CYC > RPH_CYC) ? frs_pkg::RH_CYC : RPH_CYC; // see R18 see R5

   frs_pkg::frs_host_state_e state_reg, state_next;
   frs_pkg::frs_cnt_t timer_reg;
   logic [1:0] sw_stage_reg, sw_stage_next;
   logic [7:0] code_reg, code_next;
   logic qwr_reg, qwr_next, shared_sel_reg, shared_sel_next;
   logic cs_n_reg, rst_n_reg, cmd_valid_reg, io3_oe_reg, io3_out_reg;
   logic ready_reg, sent_reg, reissue_reg;

   wire in_state_low = (state_next == frs_pkg::FRS_H_RST_LOW);
   wire t_pu = (timer_reg == frs_pkg::frs_cnt_t'(PU_CYC - 1)); // see R19
   wire t_rs = (timer_reg == frs_pkg::frs_cnt_t'(frs_pkg::RS_CYC)); // see R6
   wire t_cs = (timer_reg == frs_pkg::frs_cnt_t'(frs_pkg::CS_CYC));
   wire t_rp = (timer_reg == frs_pkg::frs_cnt_t'(frs_pkg::RP_CYC + 1));
   wire t_hold = (timer_reg == frs_pkg::frs_cnt_t'(HOLD_CYC - 1)); // see R17
   wire t_sw = (timer_reg == frs_pkg::frs_cnt_t'(SW_CYC - 1));
   // Drive high after a quad write; never low during the select-high gap
   wire gap_drive = (state_next == frs_pkg::FRS_H_GAP) & qwr_next; // see R16 see R14
   wire pin_shared_low = in_state_low & shared_sel_next;

   always_comb
   begin
      state_next = state_reg;
      sw_stage_next = sw_stage_reg;
      code_next = code_reg;
      qwr_next = qwr_reg;
      shared_sel_next = shared_sel_reg;
      unique case (state_reg)
         frs_pkg::FRS_H_PU:
            if (t_pu)
               state_next = frs_pkg::FRS_H_SETUP; // see R3
         frs_pkg::FRS_H_SETUP:
            if (t_rs)
               state_next = frs_pkg::FRS_H_IDLE; // see R6
         frs_pkg::FRS_H_IDLE:
         begin
            if (HW_RESET_REQ)
            begin
               state_next = frs_pkg::FRS_H_RST_LOW;
               shared_sel_next = USE_SHARED_PIN;
            end
            else if (SW_RESET_REQ)
            begin
               state_next = frs_pkg::FRS_H_CMD;
               code_next = frs_pkg::RESET_ENABLE_CMD;
               sw_stage_next = 2'd1;
               qwr_next = 1'b0;
            end
            else if (CMD_REQ)
            begin
               state_next = frs_pkg::FRS_H_CMD;
               code_next = CMD_CODE;
               qwr_next = QUAD_WRITE;
            end
         end
         frs_pkg::FRS_H_CMD:
            state_next = frs_pkg::FRS_H_GAP;
         frs_pkg::FRS_H_GAP:
         begin
            if (t_cs)
            begin
               qwr_next = 1'b0;
               if (sw_stage_reg == 2'd1)
               begin
                  state_next = frs_pkg::FRS_H_CMD;
                  code_next = frs_pkg::RESET_CMD;
                  sw_stage_next = 2'd2;
               end
               else if (sw_stage_reg == 2'd2)
               begin
                  state_next = frs_pkg::FRS_H_SW_WAIT;
                  sw_stage_next = 2'd0;
               end
               else
                  state_next = frs_pkg::FRS_H_IDLE;
            end
         end
         frs_pkg::FRS_H_RST_LOW:
            if (t_rp)
               state_next = frs_pkg::FRS_H_RST_HOLD;
         frs_pkg::FRS_H_RST_HOLD:
            if (t_hold)
               state_next = frs_pkg::FRS_H_SETUP; // see R5
         frs_pkg::FRS_H_SW_WAIT:
            if (t_sw)
               state_next = frs_pkg::FRS_H_SETUP;
      endcase
   end

   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         state_reg <= frs_pkg::FRS_H_PU;
         timer_reg <= '0;
         sw_stage_reg <= 2'd0;
         code_reg <= 8'h00;
         qwr_reg <= 1'b0;
         shared_sel_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         timer_reg <= (state_next != state_reg) ? '0 : timer_reg + 1'b1;
         sw_stage_reg <= sw_stage_next;
         code_reg <= code_next;
         qwr_reg <= qwr_next;
         shared_sel_reg <= shared_sel_next;
      end
   end

   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         cs_n_reg <= 1'b1;
         rst_n_reg <= 1'b1;
         cmd_valid_reg <= 1'b0;
         io3_oe_reg <= 1'b0;
         io3_out_reg <= 1'b1;
         ready_reg <= 1'b0;
         sent_reg <= 1'b0;
         reissue_reg <= 1'b0;
      end
      else
      begin
         cs_n_reg <= (state_next != frs_pkg::FRS_H_CMD); // see R17 see R3
         rst_n_reg <= ~(in_state_low & ~shared_sel_next);
         cmd_valid_reg <= (state_next == frs_pkg::FRS_H_CMD);
         io3_oe_reg <= pin_shared_low | gap_drive;
         io3_out_reg <= ~pin_shared_low;
         ready_reg <= (state_next == frs_pkg::FRS_H_IDLE);
         sent_reg <= (state_reg == frs_pkg::FRS_H_CMD);
         // Set wins over acknowledge
         if (state_reg == frs_pkg::FRS_H_IDLE && in_state_low && OP_IN_FLIGHT)
            reissue_reg <= 1'b1; // see R1
         else if (REISSUE_ACK)
            reissue_reg <= 1'b0;
      end
   end

   assign LINK.cs_n = cs_n_reg;
   assign LINK.rst_n = rst_n_reg;
   assign LINK.cmd_valid = cmd_valid_reg;
   assign LINK.cmd_byte = code_reg;
   assign LINK.host_io3_oe = io3_oe_reg;
   assign LINK.host_io3_out = io3_out_reg;
   assign HOST_READY = ready_reg;
   assign CMD_SENT = sent_reg;
   assign REISSUE_NEEDED = reissue_reg;

endmodule

// [sim/frs_chk.sv]
// Link checker for the flash reset sequencer, watching the shared link.
// Assumes both ends share REF_CLK; link signals arrive as plain inputs.
module frs_chk #(
   parameter int PU_CYC = frs_pkg::PU_CYC_DEF
) (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   // Link signals
   input wire logic cs_n,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire logic host_io3_out,
   input wire logic host_io3_oe,
   input wire logic dev_io3_out,
   input wire logic dev_io3_oe
);
   localparam int SAT = 100000;
   int pu_cnt;
   int cs_hi_cnt;
   int rst_hi_cnt;
   int rst_lo_cnt;

   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);

   // Saturating run lengths, so a long idle never wraps into a short one
   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         pu_cnt <= 0;
         cs_hi_cnt <= 0;
         rst_hi_cnt <= 0;
         rst_lo_cnt <= 0;
      end
      else
      begin
         pu_cnt <= pu_cnt + int'(pu_cnt < SAT);
         cs_hi_cnt <= cs_n ? cs_hi_cnt + int'(cs_hi_cnt < SAT) : 0;
         rst_hi_cnt <= rst_n ? rst_hi_cnt + int'(rst_hi_cnt < SAT) : 0;
         rst_lo_cnt <= !rst_n ? rst_lo_cnt + int'(rst_lo_cnt < SAT) : 0;
      end
   end

   pu_quiet_a: assert property (pu_cnt < PU_CYC |-> cs_n && rst_n && !host_io3_oe)
      else $error("host active during power-up");
   cmd_framed_a: assert property (cmd_valid |-> !cs_n ##1 cs_n)
      else $error("command not framed by select");
   cs_gap_a: assert property ($fell(cs_n) |-> cs_hi_cnt >= frs_pkg::CS_CYC)
      else $error("select high gap too short");
   rst_width_a: assert property ($rose(rst_n) |-> rst_lo_cnt > frs_pkg::RP_CYC)
      else $error("reset pulse too short");
   rst_setup_a: assert property ($fell(rst_n) |-> rst_hi_cnt > frs_pkg::RS_CYC)
      else $error("reset setup too short");
   cs_after_rst_a: assert property ($fell(cs_n) |-> rst_hi_cnt >= frs_pkg::RH_CYC)
      else $error("select low too soon after reset");
   rst_cs_high_a: assert property (!rst_n |-> cs_n)
      else $error("select low during reset pulse");
   // Device sees select rise a cycle late, so its last data bit stands one cycle
   dev_gap_high_a: assert property (dev_io3_oe && cs_n && cs_hi_cnt > 0 |->
      dev_io3_out && cs_hi_cnt <= frs_pkg::CS_CYC + 1)
      else $error("device drive on shared pin while deselected");
   host_gap_high_a: assert property (host_io3_oe && cs_n && cs_hi_cnt < frs_pkg::CS_CYC |-> host_io3_out)
      else $error("host shared pin not high in gap");
   io3_low_ok_a: assert property (host_io3_oe && !host_io3_out |-> cs_n && cs_hi_cnt >= frs_pkg::CS_CYC)
      else $error("host pulls shared pin low too early");
endmodule

// [sim/flash_reset_sequencer_bench.sv]
// Self-checking bench: host and device joined through the link interface.
// Assumes small interval counts, set alike on both ends.
module flash_reset_sequencer_bench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int PU = 50;
   localparam int RPH = 60;
   localparam int SW = 20;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] cfg1 = 8'h02;
   logic [7:0] cfg2 = 8'h08;
   logic [7:0] cfg_nv = 8'h80;
   logic por_fault = 1'b0, quad_read = 1'b0, io3_tx = 1'b1, io3_tx_en = 1'b0;
   logic hw_req = 1'b0, use_sh = 1'b0, sw_req = 1'b0, cmd_req = 1'b0;
   logic [7:0] cmd_code = 8'h00;
   logic quad_write = 1'b0, op_if = 1'b0, reissue_ack = 1'b0;
   logic por_busy, hw_busy, sw_busy, reg_restore, cmd_ready, cmd_vo, io3_rx;
   logic host_ready, cmd_sent, reissue;
   logic [7:0] cmd_bo;
   logic [9:0] exp_q[$];
   logic [9:0] mon_seen;
   int failures = 0;
   int n_tests = 0;
   int seed = 8;

   always #2.5 ref_clk = ~ref_clk;

   frs_link_if frs_link_if_i ();
   frs_device #(.PU_CYC(PU), .RPH_CYC(RPH), .SW_CYC(SW)) frs_device_i (.REF_CLK(ref_clk), .SYS_RST(sys_rst),
      .LINK(frs_link_if_i), .CONFIG_ONE(cfg1), .CONFIG_TWO(cfg2), .CONFIG_TWO_NV(cfg_nv), .POR_FAULT(por_fault),
      .QUAD_READ(quad_read), .IO3_TX(io3_tx), .IO3_TX_EN(io3_tx_en), .POR_BUSY(por_busy), .HW_RESET_BUSY(hw_busy),
      .SW_RESET_BUSY(sw_busy), .REG_RESTORE(reg_restore), .CMD_READY(cmd_ready), .CMD_VALID_OUT(cmd_vo),
      .CMD_BYTE_OUT(cmd_bo), .IO3_RX(io3_rx));
   frs_host #(.PU_CYC(PU), .RPH_CYC(RPH), .SW_CYC(SW)) frs_host_i (.REF_CLK(ref_clk), .SYS_RST(sys_rst),
      .LINK(frs_link_if_i), .HW_RESET_REQ(hw_req), .USE_SHARED_PIN(use_sh), .SW_RESET_REQ(sw_req),
      .CMD_REQ(cmd_req), .CMD_CODE(cmd_code), .QUAD_WRITE(quad_write), .OP_IN_FLIGHT(op_if),
      .REISSUE_ACK(reissue_ack), .HOST_READY(host_ready), .CMD_SENT(cmd_sent), .REISSUE_NEEDED(reissue));
   frs_chk #(.PU_CYC(PU)) frs_chk_i (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .cs_n(frs_link_if_i.cs_n),
      .rst_n(frs_link_if_i.rst_n), .cmd_valid(frs_link_if_i.cmd_valid), .host_io3_out(frs_link_if_i.host_io3_out),
      .host_io3_oe(frs_link_if_i.host_io3_oe), .dev_io3_out(frs_link_if_i.dev_io3_out),
      .dev_io3_oe(frs_link_if_i.dev_io3_oe));

   task automatic summarize();
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wait_ready();
      int i;
      i = 0;
      repeat (3) @(posedge ref_clk);
      while (!(host_ready === 1'b1 && cmd_ready === 1'b1) && i < 1000)
      begin
         @(posedge ref_clk);
         i++;
      end
      chk("ready", 1, int'(i < 1000));
   endtask

   // Random code, never one of the two reset commands
   task automatic cmd();
      int r;
      logic [7:0] c;
      r = $random(seed);
      c = r[7:0];
      if (c == 8'h66 || c == 8'h99)
         c[0] = ~c[0];
      exp_q.push_back({2'd0, c});
      @(posedge ref_clk);
      cmd_req <= 1'b1;
      cmd_code <= c;
      quad_write <= r[8];
      quad_read <= r[9];
      io3_tx <= r[10];
      io3_tx_en <= r[11];
      @(posedge ref_clk);
      cmd_req <= 1'b0;
      wait_ready();
   endtask

   // Kind 0 means the pulse must be ignored
   task automatic hw(input logic sh, input logic [1:0] kind);
      int i;
      i = 0;
      if (kind != 2'd0)
         exp_q.push_back({kind, 8'h00});
      @(posedge ref_clk);
      hw_req <= 1'b1;
      use_sh <= sh;
      @(posedge ref_clk);
      hw_req <= 1'b0;
      while (reg_restore !== 1'b1 && i < 100)
      begin
         @(posedge ref_clk);
         i++;
      end
      if (kind != 2'd0)
      begin
         chk("cmd_ready", 0, cmd_ready);
         chk("dev_io3_oe", 0, frs_link_if_i.dev_io3_oe);
      end
      wait_ready();
   endtask

   always @(posedge ref_clk)
   begin
      if (!sys_rst && (reg_restore === 1'b1 || (cmd_vo === 1'b1 && cmd_bo !== 8'h66 && cmd_bo !== 8'h99)))
      begin
         mon_seen = reg_restore ? {(hw_busy ? 2'd1 : sw_busy ? 2'd2 : por_busy ? 2'd3 : 2'd0), 8'h00} : {2'd0, cmd_bo};
         if (exp_q.size() == 0)
            chk("event", 32'h400, {22'h0, mon_seen});
         else
            chk("event", {22'h0, exp_q.pop_front()}, {22'h0, mon_seen});
      end
      // Host flags the send as the device passes it on; pin idles high under select
      if (!sys_rst && cmd_vo === 1'b1)
      begin
         chk("cmd_sent", 1, cmd_sent);
         chk("io3_rx", 1, io3_rx);
      end
   end

   initial
   begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      $display("ERROR watchdog expected done seen timeout");
      summarize();
   end

   initial
   begin
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (PU - 5) @(posedge ref_clk);
      chk("por_busy", 1, por_busy);
      chk("host_ready", 0, host_ready);
      wait_ready();
      repeat (4) cmd();
      exp_q.push_back({2'd2, 8'h00});
      @(posedge ref_clk);
      sw_req <= 1'b1;
      @(posedge ref_clk);
      sw_req <= 1'b0;
      wait_ready();
      cmd();
      @(posedge ref_clk);
      op_if <= 1'b1;
      hw(1'b0, 2'd1);
      chk("reissue", 1, reissue);
      op_if <= 1'b0;
      reissue_ack <= 1'b1;
      @(posedge ref_clk);
      reissue_ack <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk("reissue", 0, reissue);
      cmd();
      // Shared pin across enable and quad settings
      for (int k = 0; k < 4; k++)
      begin
         @(posedge ref_clk);
         cfg_nv <= (k < 2) ? 8'h80 : 8'h00;
         cfg1 <= k[0] ? 8'h00 : 8'h02;
         hw(1'b1, (k < 2) ? 2'd1 : 2'd0);
         cmd();
      end
      // Second power-up that faults, then a pin reset runs full power-on
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      por_fault <= 1'b1;
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      wait_ready();
      por_fault <= 1'b0;
      hw(1'b0, 2'd3);
      hw(1'b0, 2'd1);
      cmd();
      chk("queue_left", 0, exp_q.size());
      summarize();
   end
endmodule
